// [hw/fbad_decode.sv]
// Flash address decoder: registers requests toward the array and
// returns one response per accepted request; assumes array answers reads
// within the cycle it is addressed.
`timescale 1ns/100ps
`include "fbad_defines.svh"
module fbad_decode #(
  parameter int NUM_SECT   = `FBAD_NUM_SECT,
  parameter int NUM_PAGE   = `FBAD_NUM_PAGE,
  parameter int NUM_BLK    = `FBAD_NUM_BLK,
  parameter int DATA_BYTES = `FBAD_DATA_BYTES,
  parameter int AUX_BYTES  = `FBAD_AUX_BYTES
) (
  input  wire logic                   mclk_i,
  input  wire logic                   rstn_i,
  input  wire fbad_pkg::fbad_req_type req_i,
  input  wire logic [`FBAD_DATA_W-1:0] arr_rdata_i,
  output fbad_pkg::fbad_arr_type      arr_o,
  output fbad_pkg::fbad_rsp_type      rsp_o
);
  import fbad_pkg::*;

  // All checks run on the one clock and sleep during reset
  default clocking cb_main @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  // Shared by the array gate and the response error flag
  function automatic logic refuse_write(input logic rsvd_hit,
                                        input logic is_write);
    return rsvd_hit && is_write;
  endfunction : refuse_write

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } fbad_state_type;

  fbad_arr_type   split;
  logic           rsvd;
  fbad_state_type state_ff, nxt_state;
  fbad_arr_type   arr_ff, nxt_arr;
  fbad_rsp_type   rsp_ff, nxt_rsp;
  logic           rsvd_ff, nxt_rsvd;
  logic           wr_ff, nxt_wr;

  fbad_field_split u_split (
    .req_i  (req_i),
    .arr_o  (split),
    .rsvd_o (rsvd)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_arr   = arr_ff;
    nxt_rsp   = '0;
    nxt_rsvd  = rsvd_ff;
    nxt_wr    = wr_ff;
    nxt_arr.valid = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (req_i.valid) begin
          nxt_arr = split;
          // Reserved page never reaches the array on a write
          nxt_arr.valid = !refuse_write(rsvd, req_i.write);
          nxt_rsvd  = rsvd;
          nxt_wr    = req_i.write;
          nxt_state = ST_RESP;
        end
      end
      ST_RESP: begin
        nxt_rsp.valid = 1'b1;
        nxt_rsp.error = refuse_write(rsvd_ff, wr_ff);
        nxt_rsp.rdata = (rsvd_ff || wr_ff) ? '0 : arr_rdata_i;
        nxt_state     = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= ST_IDLE;
      arr_ff   <= '0;
      rsp_ff   <= '0;
      rsvd_ff  <= 1'b0;
      wr_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      arr_ff   <= nxt_arr;
      rsp_ff   <= nxt_rsp;
      rsvd_ff  <= nxt_rsvd;
      wr_ff    <= nxt_wr;
    end
  end

  assign arr_o = arr_ff;
  assign rsp_o = rsp_ff;

  // Request shapes, each taken only in the idle state
  sequence s_take;
    req_i.valid && state_ff == ST_IDLE;
  endsequence

  sequence s_rsvd_write;
    req_i.valid && req_i.write && rsvd && state_ff == ST_IDLE;
  endsequence

  sequence s_rsvd_read;
    req_i.valid && !req_i.write && rsvd && state_ff == ST_IDLE;
  endsequence

  sequence s_plain_write;
    req_i.valid && req_i.write && !rsvd && state_ff == ST_IDLE;
  endsequence

  sequence s_plain_read;
    req_i.valid && !req_i.write && !rsvd && state_ff == ST_IDLE;
  endsequence

  // One quiet cycle, then the answer in the response slot
  sequence s_resp_slot;
    !rsp_o.valid ##1 rsp_o.valid;
  endsequence

  property p_rsvd_write;
    s_rsvd_write |=> !arr_o.valid ##1 (rsp_o.valid && rsp_o.error);
  endproperty
  a_rsvd_write_err: assert property (p_rsvd_write)
    else $error("reserved write not refused");

  property p_rsvd_no_store;
    (arr_o.valid && arr_o.write) |->
      !(arr_o.spare && arr_o.sector == `FBAD_RSVD_SECT);
  endproperty
  a_rsvd_no_store: assert property (p_rsvd_no_store)
    else $error("reserved page write reached array");

  property p_rsvd_read;
    s_rsvd_read |=> ##1
      (rsp_o.valid && rsp_o.rdata == '0 && !rsp_o.error);
  endproperty
  a_rsvd_read_zero: assert property (p_rsvd_read)
    else $error("reserved read not zero");

  // Only the reserved page is zeroed; every other read passes through
  property p_read_data;
    s_plain_read |=> ##1
      (rsp_o.valid && !rsp_o.error && rsp_o.rdata == $past(arr_rdata_i));
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("array read data not returned");

  property p_write_done;
    s_plain_write |=> ##1
      (rsp_o.valid && !rsp_o.error && rsp_o.rdata == '0);
  endproperty
  a_write_done: assert property (p_write_done)
    else $error("normal write response wrong");

  property p_err_slot;
    rsp_o.error |-> rsp_o.valid && $past(state_ff) == ST_RESP;
  endproperty
  a_err_slot: assert property (p_err_slot)
    else $error("error outside response slot");

  property p_one_resp;
    s_take |=> s_resp_slot;
  endproperty
  a_one_resp: assert property (p_one_resp)
    else $error("response missing");

  // A request in the response cycle is dropped, not queued
  property p_busy_drop;
    (req_i.valid && state_ff == ST_RESP) |=> !arr_o.valid;
  endproperty
  a_busy_drop: assert property (p_busy_drop)
    else $error("request taken while busy");

  property p_sector_field;
    s_take |=>
      arr_o.sector == $past(req_i.addr[`FBAD_SECT_HI:`FBAD_SECT_LO]);
  endproperty
  a_sector_field: assert property (p_sector_field)
    else $error("sector field wrong");

  // Catches a geometry parameter set narrower than the fields
  property p_geometry;
    arr_o.valid |->
      int'(arr_o.sector) < NUM_SECT && int'(arr_o.page) < NUM_PAGE &&
      int'(arr_o.block) < NUM_BLK && int'(arr_o.byte_sel) < DATA_BYTES;
  endproperty
  a_geometry_range: assert property (p_geometry)
    else $error("field beyond geometry");

  property p_field_split;
    (req_i.valid && state_ff == ST_IDLE && !req_i.spare && !req_i.aux) |=>
      arr_o.page == $past(req_i.addr[`FBAD_PAGE_HI:`FBAD_PAGE_LO]) &&
      arr_o.block == $past(req_i.addr[`FBAD_BLK_HI:`FBAD_BLK_LO]) &&
      arr_o.byte_sel == $past(req_i.addr[`FBAD_BYTE_HI:`FBAD_BYTE_LO]);
  endproperty
  a_field_split: assert property (p_field_split)
    else $error("address fields wrong");

  property p_spare_page;
    (req_i.valid && state_ff == ST_IDLE && req_i.spare) |=>
      arr_o.spare && arr_o.page == 5'h00;
  endproperty
  a_spare_page: assert property (p_spare_page)
    else $error("spare select kept page");

  property p_spare_alone;
    (arr_o.valid && arr_o.spare) |-> arr_o.page == 5'h00;
  endproperty
  a_spare_alone: assert property (p_spare_alone)
    else $error("spare page mixed with page field");

  property p_aux_bytes;
    (req_i.valid && state_ff == ST_IDLE && req_i.aux) |=>
      arr_o.aux && arr_o.block == 3'h0 &&
      arr_o.byte_sel == {2'h0, $past(req_i.addr[`FBAD_AUXB_HI:0])};
  endproperty
  a_aux_bytes: assert property (p_aux_bytes)
    else $error("aux select kept bits");

  property p_aux_block;
    (arr_o.valid && arr_o.aux) |-> arr_o.block == 3'h0;
  endproperty
  a_aux_block: assert property (p_aux_block)
    else $error("aux block mixed with block field");

  property p_aux_range;
    (arr_o.valid && arr_o.aux) |-> int'(arr_o.byte_sel) < AUX_BYTES;
  endproperty
  a_aux_range: assert property (p_aux_range)
    else $error("aux byte beyond aux block");
endmodule : fbad_decode

// [hw/fbad_defines.svh]
// Address field positions and geometry constants for the flash decoder.
// Included by the package and the decoder modules; definitions only.
`ifndef FBAD_DEFINES_SVH
`define FBAD_DEFINES_SVH
`define FBAD_ADDR_W      18
`define FBAD_SECT_HI     17
`define FBAD_SECT_LO     12
`define FBAD_PAGE_HI     11
`define FBAD_PAGE_LO     7
`define FBAD_BLK_HI      6
`define FBAD_BLK_LO      4
`define FBAD_BYTE_HI     3
`define FBAD_BYTE_LO     0
`define FBAD_AUXB_HI     1
`define FBAD_NUM_SECT    64
`define FBAD_NUM_PAGE    32
`define FBAD_NUM_BLK     8
`define FBAD_DATA_BYTES  16
`define FBAD_AUX_BYTES   4
`define FBAD_RSVD_SECT   6'h00
`define FBAD_DATA_W      8
`endif

// [hw/fbad_pkg.sv]
// Types shared by the flash address decoder and its caller.
// Assumes the defines header is on the include path.
`include "fbad_defines.svh"
package fbad_pkg;
  typedef struct packed {
    logic                     valid;
    logic                     write;
    logic                     spare;
    logic                     aux;
    logic [`FBAD_ADDR_W-1:0]  addr;
    logic [`FBAD_DATA_W-1:0]  wdata;
  } fbad_req_type;

  typedef struct packed {
    logic                     valid;
    logic                     write;
    logic                     spare;
    logic                     aux;
    logic [5:0]               sector;
    logic [4:0]               page;
    logic [2:0]               block;
    logic [3:0]               byte_sel;
    logic [`FBAD_DATA_W-1:0]  wdata;
  } fbad_arr_type;

  typedef struct packed {
    logic                     valid;
    logic                     error;
    logic [`FBAD_DATA_W-1:0]  rdata;
  } fbad_rsp_type;
endpackage : fbad_pkg

// [hw/fbad_field_split.sv]
// Combinational split of a request address into array fields.
// Assumes request arrives on the same clock as the caller.
`timescale 1ns/100ps
`include "fbad_defines.svh"
module fbad_field_split (
  input  wire fbad_pkg::fbad_req_type req_i,
  output fbad_pkg::fbad_arr_type      arr_o,
  output logic                        rsvd_o
);
  import fbad_pkg::*;

  always_comb begin
    arr_o.valid    = req_i.valid;
    arr_o.write    = req_i.write;
    arr_o.spare    = req_i.spare;
    arr_o.aux      = req_i.aux;
    arr_o.wdata    = req_i.wdata;
    arr_o.sector   = req_i.addr[`FBAD_SECT_HI:`FBAD_SECT_LO];
    arr_o.page     = req_i.addr[`FBAD_PAGE_HI:`FBAD_PAGE_LO];
    arr_o.block    = req_i.addr[`FBAD_BLK_HI:`FBAD_BLK_LO];
    arr_o.byte_sel = req_i.addr[`FBAD_BYTE_HI:`FBAD_BYTE_LO];
    if (req_i.spare) begin
      arr_o.page = 5'h00;
    end
    if (req_i.aux) begin
      arr_o.block    = 3'h0;
      arr_o.byte_sel = {2'h0, req_i.addr[`FBAD_AUXB_HI:0]};
    end
  end

  assign rsvd_o = req_i.spare &&
                  (arr_o.sector == `FBAD_RSVD_SECT);
endmodule : fbad_field_split

// [bench/fbad_array_model.sv]
// Flash array stand-in: stores written bytes, answers reads mid-cycle.
// Assumes arr_i is the decoder's registered request; the decoder takes
// read data at the rising edge that ends the addressed cycle.
`timescale 1ns/100ps
module fbad_array_model (
  input  wire logic                   mclk_i,
  input  wire fbad_pkg::fbad_arr_type arr_i,
  output logic [7:0]                  rdata_o = 8'h00
);
  import fbad_pkg::*;
  logic [7:0] mem [int];
  int         key;
  always @(negedge mclk_i) begin
    key = {arr_i.spare, arr_i.aux, arr_i.sector, arr_i.page,
           arr_i.block, arr_i.byte_sel};
    if (arr_i.valid && arr_i.write)
      mem[key] = arr_i.wdata;
    // Idle data toggles so a stale byte never passes as fresh
    if (arr_i.valid && !arr_i.write)
      rdata_o <= mem.exists(key) ? mem[key] : 8'hc3;
    else
      rdata_o <= ~rdata_o;
  end
endmodule : fbad_array_model

// [bench/tb.sv]
// Bench: random write/read-back pairs, reference model, compares.
// Assumes one request every two cycles and the array stand-in.
`timescale 1ns/100ps
module tb;
  import fbad_pkg::*;
  logic         mclk_i = 1'b0;
  logic         rstn_i = 1'b0;
  fbad_req_type req_i  = '0;
  logic [7:0]   arr_rdata;
  fbad_arr_type arr_o;
  fbad_rsp_type rsp_o;
  int           miscompares = 0;
  int           num_checks = 0;
  logic [7:0]   mem [int];
  fbad_decode i_fbad_decode (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .req_i(req_i), .arr_rdata_i(arr_rdata), .arr_o(arr_o), .rsp_o(rsp_o));
  fbad_array_model i_fbad_array_model (.mclk_i(mclk_i), .arr_i(arr_o),
    .rdata_o(arr_rdata));
  always #2 mclk_i = ~mclk_i;
  task automatic chk(string n, logic [19:0] s, logic [19:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic xfer(logic w, logic s, logic x, logic [17:0] a,
                      logic [7:0] d);
    logic        rsv;
    logic [7:0]  rd;
    logic [19:0] k;
    logic [19:0] f;
    logic [9:0]  e;
    rsv = s && a[17:12] == 6'h00;
    k = {s, x, a[17:12], s ? 5'h00 : a[11:7], x ? 3'h0 : a[6:4],
         x ? {2'h0, a[1:0]} : a[3:0]};
    rd = (w || rsv) ? 8'h00 : (mem.exists(k) ? mem[k] : 8'hc3);
    e = {1'b1, rsv && w, rd};
    if (w && !rsv)
      mem[k] = d;
    req_i <= '{1'b1, w, s, x, a, d};
    @(negedge mclk_i);
    // A request in the busy cycle must be dropped
    req_i.valid <= 1'($urandom);
    f = {arr_o.spare, arr_o.aux, arr_o.sector, arr_o.page, arr_o.block,
         arr_o.byte_sel};
    chk("arr_valid", arr_o.valid, !(rsv && w));
    if (!(rsv && w)) begin
      chk("arr_addr", f, k);
      chk("arr_data", {arr_o.write, arr_o.wdata}, {w, d});
    end
    @(negedge mclk_i);
    chk("rsp", {rsp_o.valid, rsp_o.error, rsp_o.rdata}, e);
    chk("arr_drop", arr_o.valid, 1'b0);
  endtask : xfer
  initial begin
    logic [17:0] a;
    logic        s;
    logic        x;
    void'($urandom(32'hf755));
    repeat (16) @(negedge mclk_i);
    rstn_i = 1'b1;
    repeat (150) begin
      a = 18'($urandom);
      if ($urandom % 4 == 0)
        a[17:12] = 6'h00;
      s = 1'($urandom);
      x = 1'($urandom);
      xfer(1'b1, s, x, a, 8'($urandom));
      // Read back with the ignored bits scrambled
      if (s)
        a[11:7] = 5'($urandom);
      if (x)
        a[6:2] = 5'($urandom);
      xfer(1'b0, s, x, a, 8'($urandom));
    end
    end_of_test();
  end
  initial begin
    #20000;
    miscompares++;
    end_of_test();
  end
endmodule : tb
